// ### include/tap_ctrl_pkg.sv
package tap_ctrl_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int POS_W = 5;
    localparam int TAPS = 32;
    localparam int DEBOUNCE_MS = 40;
    localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int SLOW_PHASE_MS = 1000;
    localparam int SLOW_PHASE_CYC = CLK_HZ / 1000 * SLOW_PHASE_MS;
    localparam int SLOW_PERIOD_MS = 250;
    localparam int SLOW_PERIOD_CYC = CLK_HZ / 1000 * SLOW_PERIOD_MS;
    localparam int FAST_PERIOD_MS = 50;
    localparam int FAST_PERIOD_CYC = CLK_HZ / 1000 * FAST_PERIOD_MS;
    localparam int TIMER_W = 32;
    localparam logic [4:0] POS_TOP = 5'h1F;
    localparam logic [4:0] POS_BOTTOM = 5'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SLOW = 2'b01,
        ST_FAST = 2'b11
    } scan_state_t;
endpackage : tap_ctrl_pkg

// ### rtl/input_debounce.sv
module input_debounce #(
    parameter int COUNT = 2_000_000
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // raw and filtered level
    input wire logic raw_n,
    output logic clean_n
);
    import tap_ctrl_pkg::*;

    logic [TIMER_W-1:0] cnt_q, cnt_d;
    logic clean_q, clean_d;

    // a level must stay put for the full interval; any bounce restarts it
    always_comb begin
        cnt_d = '0;
        clean_d = clean_q;
        if (raw_n != clean_q) begin
            cnt_d = cnt_q + 32'h1;
            if (cnt_q >= TIMER_W'(COUNT - 1)) begin
                clean_d = raw_n;
                cnt_d = '0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
            clean_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            clean_q <= clean_d;
        end
    end

    assign clean_n = clean_q;
endmodule : input_debounce

// ### rtl/tap_control.sv
module tap_control
    import tap_ctrl_pkg::*;
#(
    parameter int DEBOUNCE = DEBOUNCE_CYC,
    parameter int SLOW_PHASE = SLOW_PHASE_CYC,
    parameter int SLOW_PERIOD = SLOW_PERIOD_CYC,
    parameter int FAST_PERIOD = FAST_PERIOD_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // push inputs
    input wire logic up_request_n,
    input wire logic down_request_n,
    input wire logic save_enable_n,
    // supply monitor
    input wire logic power_fail,
    // nonvolatile store port
    input wire logic [POS_W-1:0] nv_data,
    output logic nv_write,
    output logic [POS_W-1:0] nv_wdata,
    // wiper
    output logic [TAPS-1:0] tap_select,
    output logic [POS_W-1:0] position
);
    import tap_ctrl_pkg::*;

    logic up_n, down_n, save_n;

    // each push pin has its own filter: a level counts only after it has held
    // still for the whole interval, which also swallows contact bounce;
    // the cost is that every answer lags the pin by that interval
    input_debounce #(.COUNT(DEBOUNCE)) u_db_up (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .raw_n(up_request_n),
        .clean_n(up_n)
    );
    input_debounce #(.COUNT(DEBOUNCE)) u_db_down (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .raw_n(down_request_n),
        .clean_n(down_n)
    );
    input_debounce #(.COUNT(DEBOUNCE)) u_db_save (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .raw_n(save_enable_n),
        .clean_n(save_n)
    );

    // power-up bookkeeping
    logic loaded_q, loaded_d;
    logic auto_q, auto_d;       // save-enable low when loaded: automatic_save
    logic lock_q, lock_d;
    logic save_prev_q, save_prev_d;
    logic fail_prev_q, fail_prev_d;

    // scan state
    // hold times the whole press for the switch to fast scan, rep the gap
    // since the last step; both are full width so long phases still fit
    scan_state_t state_q, state_d;
    logic [TIMER_W-1:0] hold_q, hold_d;
    logic [TIMER_W-1:0] rep_q, rep_d;
    logic [POS_W-1:0] pos_q, pos_d;
    logic wr_q, wr_d;
    logic [POS_W-1:0] wdata_q, wdata_d;
    logic [TAPS-1:0] sel_q, sel_d;

    logic up_req, down_req, any_req, step, store_req;
    logic fail_edge, release_edge;

    // power-up bookkeeping: the first edge after reset loads and picks mode
    always_comb begin
        loaded_d = 1'b1;
        // the mode is taken from the raw pin on the first edge after reset:
        // the filter still shows its idle high level there, so a pin tied
        // low for automatic saving would otherwise never be seen
        auto_d = loaded_q ? auto_q : !save_enable_n;
        save_prev_d = save_n;
        fail_prev_d = power_fail;
        lock_d = lock_q;
        if (loaded_q && !auto_q) begin
            // manual mode: low pulse on save-enable locks requests until high
            // so that a request passing its filter after the filtered save-enable falls never moves the wiper
            lock_d = !save_n;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            loaded_q <= 1'b0;
            auto_q <= 1'b0;
            lock_q <= 1'b0;
            save_prev_q <= 1'b1;
            fail_prev_q <= 1'b0;
        end else begin
            loaded_q <= loaded_d;
            auto_q <= auto_d;
            lock_q <= lock_d;
            save_prev_q <= save_prev_d;
            fail_prev_q <= fail_prev_d;
        end
    end

    // scan control: the first step comes at once, repeats wait a period
    always_comb begin
        up_req = !up_n && down_n && !lock_q;
        down_req = !down_n && up_n && !lock_q;
        any_req = up_req || down_req;
        state_d = state_q;
        hold_d = hold_q;
        rep_d = rep_q;
        step = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (any_req) begin
                    step = 1'b1;
                    state_d = ST_SLOW;
                    hold_d = '0;
                    rep_d = '0;
                end
            end
            ST_SLOW, ST_FAST: begin
                if (!any_req) begin
                    state_d = ST_IDLE;
                end else begin
                    hold_d = hold_q + 32'h1;
                    rep_d = rep_q + 32'h1;
                    if (state_q == ST_SLOW &&
                        hold_q >= TIMER_W'(SLOW_PHASE - 1)) begin
                        state_d = ST_FAST;
                    end
                    if ((state_q == ST_SLOW &&
                         rep_q >= TIMER_W'(SLOW_PERIOD - 1)) ||
                        (state_q == ST_FAST &&
                         rep_q >= TIMER_W'(FAST_PERIOD - 1))) begin
                        step = 1'b1;
                        rep_d = '0;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // timers only run during a press, so an idle device holds still
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            hold_q <= '0;
            rep_q <= '0;
        end else begin
            state_q <= state_d;
            hold_q <= hold_d;
            rep_q <= rep_d;
        end
    end

    // wiper position and store strobe
    always_comb begin
        // the load happens only on the first edge, before any request can
        // have passed its filter
        pos_d = pos_q;
        if (!loaded_q) begin
            pos_d = nv_data;
        end else if (step && up_req && pos_q != POS_TOP) begin
            pos_d = pos_q + 5'h01;
        end else if (step && down_req && pos_q != POS_BOTTOM) begin
            pos_d = pos_q - 5'h01;
        end
        // automatic mode stores once on the rising edge of the fail flag while the filtered save-enable is low;
        // a flag that stays high does not wear the cell with repeats
        fail_edge = auto_q && !save_n && power_fail && !fail_prev_q;
        // manual mode stores on the filtered release of the store button,
        // so a bouncing contact cannot start more than one write
        release_edge = !auto_q && save_n && !save_prev_q;
        // the load edge never stores: loaded_q masks both sources
        store_req = loaded_q && (fail_edge || release_edge);
        wr_d = store_req;
        // take the value that the wiper shows while the strobe stands
        wdata_d = store_req ? pos_d : wdata_q;
        // tap_select follows pos_d so it moves on the same edge as position
        sel_d = '0;
        sel_d[pos_d] = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pos_q <= POS_BOTTOM;
            wr_q <= 1'b0;
            wdata_q <= POS_BOTTOM;
            sel_q <= TAPS'(1);
        end else begin
            pos_q <= pos_d;
            wr_q <= wr_d;
            wdata_q <= wdata_d;
            sel_q <= sel_d;
        end
    end

    // every output comes straight from one of the registers above
    assign nv_write = wr_q;
    assign nv_wdata = wdata_q;
    assign tap_select = sel_q;
    assign position = pos_q;
endmodule : tap_control

// ### dv/tap_control_props.sv
module tap_control_props
    import tap_ctrl_pkg::*;
(
    // watched ports
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic up_request_n,
    input wire logic down_request_n,
    input wire logic save_enable_n,
    input wire logic power_fail,
    input wire logic [POS_W-1:0] nv_data,
    input wire logic nv_write,
    input wire logic [POS_W-1:0] nv_wdata,
    input wire logic [TAPS-1:0] tap_select,
    input wire logic [POS_W-1:0] position
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] age_q;
    logic auto_q;
    logic [5:0] uh_q, dh_q, sl_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // age gates off the power-up load, which is not a step
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            age_q <= 2'h0;
            uh_q <= 6'h00;
            dh_q <= 6'h00;
            sl_q <= 6'h00;
            auto_q <= 1'b0;
        end else begin
            // the store mode follows the pin at the first edge after reset
            if (age_q == 2'h0) begin
                auto_q <= !save_enable_n;
            end
            age_q <= age_q + {1'b0, ~&age_q};
            uh_q <= up_request_n ? uh_q + {5'h0, ~&uh_q} : 6'h00;
            dh_q <= down_request_n ? dh_q + {5'h0, ~&dh_q} : 6'h00;
            sl_q <= !save_enable_n ? sl_q + {5'h0, ~&sl_q} : 6'h00;
        end
    end
    a_load_value: assert property (
        age_q == 2'h1 |-> position == $past(nv_data))
        else $error("power-up load wrong");
    a_onehot_tap: assert property (
        tap_select == (32'h1 << position))
        else $error("tap select not one-hot");
    a_step_one: assert property (
        age_q == 2'h3 && position != $past(position) |->
        5'(position - $past(position)) inside {5'h01, 5'h1F})
        else $error("step not one");
    a_up_cause: assert property (
        age_q == 2'h3 && position == 5'($past(position) + 5'h01) |->
        uh_q < 6'h1E)
        else $error("rise without up");
    a_dn_cause: assert property (
        age_q == 2'h3 && position == 5'($past(position) - 5'h01) |->
        dh_q < 6'h1E)
        else $error("fall without down");
    a_top_hold: assert property (
        age_q == 2'h3 && $past(position) == 5'h1F |-> position != 5'h00)
        else $error("wrap at top");
    a_bot_hold: assert property (
        age_q == 2'h3 && $past(position) == 5'h00 |-> position != 5'h1F)
        else $error("wrap at bottom");
    a_lock_save: assert property (
        !auto_q && sl_q > 6'h18 |=> $stable(position))
        else $error("step while locked");
    a_store_pulse: assert property (
        nv_write |=> !nv_write)
        else $error("store pulse long");
    a_store_data: assert property (
        nv_write |-> nv_wdata == position)
        else $error("stored value wrong");
    a_fail_store: assert property (
        age_q == 2'h3 && auto_q && sl_q > 6'h18 && power_fail &&
        !$past(power_fail) |=> nv_write)
        else $error("no store on power fail");
endmodule : tap_control_props

// ### dv/push_model.sv
module push_model (
    // button lines
    input wire logic ref_clk,
    output logic up_request_n,
    output logic down_request_n,
    output logic save_enable_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // released lines sit high, as the pull-ups would hold them
    initial {save_enable_n, down_request_n, up_request_n} = 3'h7;
    task automatic set(input logic [2:0] sel);
        @(posedge ref_clk);
        #1 {save_enable_n, down_request_n, up_request_n} = ~sel;
    endtask : set
    // idle gap after release so the filter sees separate presses
    task automatic push(input logic [2:0] sel, input int cyc);
        set(sel);
        repeat (cyc) @(posedge ref_clk);
        set(3'h0);
        repeat (40) @(posedge ref_clk);
        #1;
    endtask : push
endmodule : push_model

// ### dv/testbench.sv
module testbench;
    import tap_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, reset_n, power_fail, nv_write;
    logic up_request_n, down_request_n, save_enable_n;
    logic [POS_W-1:0] nv_data, nv_wdata, position, p1;
    logic [TAPS-1:0] tap_select;
    int error_cnt, compares;
    tap_control #(.DEBOUNCE(20), .SLOW_PHASE(200), .SLOW_PERIOD(40),
        .FAST_PERIOD(8)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .up_request_n(up_request_n), .down_request_n(down_request_n),
        .save_enable_n(save_enable_n), .power_fail(power_fail),
        .nv_data(nv_data), .nv_write(nv_write), .nv_wdata(nv_wdata),
        .tap_select(tap_select), .position(position));
    push_model pb (.ref_clk(ref_clk), .up_request_n(up_request_n),
        .down_request_n(down_request_n), .save_enable_n(save_enable_n));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic t_steps();
        check("restored", position, 5'h1E);
        check("one-hot", tap_select, 32'h4000_0000);
        pb.push(3'h1, 10);
        check("short press", position, 5'h1E);
        pb.push(3'h1, 30);
        check("single step", position, 5'h1F);
        pb.push(3'h1, 60);
        check("top", position, 5'h1F);
        pb.push(3'h3, 100);
        check("both low", position, 5'h1F);
    endtask : t_steps
    task automatic t_hold_down();
        pb.set(3'h2);
        repeat (150) @(posedge ref_clk);
        #1 p1 = 5'h1F - position;
        check("slow scan", 32'(p1 >= 5'h02 && p1 <= 5'h05), 32'h1);
        repeat (450) @(posedge ref_clk);
        #1 check("fast scan", position, 5'h00);
        pb.push(3'h0, 1);
        pb.push(3'h1, 30);
        check("up from bottom", position, 5'h01);
        pb.set(3'h1);
        repeat (90) @(posedge ref_clk);
        pb.push(3'h0, 1);
        p1 = position;
        check("slow repeat", p1, 5'h04);
        repeat (60) @(posedge ref_clk);
        #1 check("release idle", position, p1);
    endtask : t_hold_down
    task automatic t_store();
        int n;
        pb.set(3'h4);
        repeat (30) @(posedge ref_clk);
        pb.set(3'h5);
        repeat (60) @(posedge ref_clk);
        check("locked", position, 5'h04);
        pb.set(3'h4);
        repeat (30) @(posedge ref_clk);
        pb.set(3'h0);
        for (n = 0; n < 60 && nv_write !== 1'b1; n++) @(posedge ref_clk) #1;
        check("store pulse", nv_write, 1'b1);
        if (nv_write !== 1'b1) complete_run();
        check("store value", nv_wdata, 5'h04);
    endtask : t_store
    task automatic t_auto();
        int n;
        pb.set(3'h4);
        reset_n = 1'b0;
        nv_data = 5'h03;
        repeat (4) @(posedge ref_clk);
        #1 check("in reset", position, 5'h00);
        check("reset tap", tap_select, 32'h1);
        reset_n = 1'b1;
        repeat (40) @(posedge ref_clk);
        #1 check("reload", position, 5'h03);
        pb.set(3'h5);
        repeat (30) @(posedge ref_clk);
        pb.set(3'h4);
        repeat (40) @(posedge ref_clk);
        #1 check("auto step", position, 5'h04);
        power_fail = 1'b1;
        for (n = 0; n < 10 && nv_write !== 1'b1; n++) @(posedge ref_clk) #1;
        check("auto store", nv_write, 1'b1);
        check("auto value", nv_wdata, 5'h04);
        power_fail = 1'b0;
        pb.set(3'h0);
    endtask : t_auto
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        reset_n = 1'b0;
        power_fail = 1'b0;
        nv_data = 5'h1E;
        error_cnt = 0;
        compares = 0;
        repeat (4) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        t_steps();
        t_hold_down();
        t_store();
        t_auto();
        complete_run();
    end
endmodule : testbench
bind tap_control tap_control_props props (.ref_clk(ref_clk),
    .reset_n(reset_n), .up_request_n(up_request_n),
    .down_request_n(down_request_n), .save_enable_n(save_enable_n),
    .power_fail(power_fail),
    .nv_data(nv_data), .nv_write(nv_write), .nv_wdata(nv_wdata),
    .tap_select(tap_select), .position(position));
